// *** hioad_pkg.sv ***
// shared constants and carrier types for the host i/o decode block
package hioad_pkg;
	localparam int          HIOAD_AW         = 10;
	localparam int          HIOAD_DW         = 16;
	// fixed addresses, and the ide alternate offset added to the ide base
	localparam logic [9:0]  HIOAD_CFG_INDEX  = 10'h3F0;
	localparam logic [9:0]  HIOAD_CFG_DATA   = 10'h3F1;
	localparam logic [9:0]  HIOAD_GAME_ADDR  = 10'h201;
	localparam logic [9:0]  HIOAD_IDE_ALT    = 10'h206;
	// power-up bases, stored as address bits [9:2]
	localparam logic [7:0]  HIOAD_FDC_RST    = 8'hFC;
	localparam logic [7:0]  HIOAD_IDE_RST    = 8'h7C;
	localparam logic [7:0]  HIOAD_COM1_RST   = 8'hFE;
	localparam logic [7:0]  HIOAD_COM2_RST   = 8'hBE;
	localparam logic [7:0]  HIOAD_PAR_RST    = 8'h9E;
	// offsets inside a floppy block, and the last parallel offset
	localparam logic [2:0]  HIOAD_FO_STA     = 3'h0;
	localparam logic [2:0]  HIOAD_FO_STB     = 3'h1;
	localparam logic [2:0]  HIOAD_FO_DOR     = 3'h2;
	localparam logic [2:0]  HIOAD_FO_FIFO    = 3'h5;
	localparam logic [2:0]  HIOAD_FO_DIR     = 3'h7;
	localparam logic [1:0]  HIOAD_PAR_LAST   = 2'h2;
	// configuration mode keys
	localparam logic [7:0]  HIOAD_KEY_ENTER  = 8'h55;
	localparam logic [7:0]  HIOAD_KEY_EXIT   = 8'hAA;
	// configuration register indexes
	localparam logic [7:0]  HIOAD_CR_MODE    = 8'h00;
	localparam logic [7:0]  HIOAD_CR_FDC     = 8'h01;
	localparam logic [7:0]  HIOAD_CR_IDE     = 8'h02;
	localparam logic [7:0]  HIOAD_CR_COM1    = 8'h03;
	localparam logic [7:0]  HIOAD_CR_COM2    = 8'h04;
	localparam logic [7:0]  HIOAD_CR_PAR     = 8'h05;
	// mode and digital output register fields and reset values, and the ide bit 7 index
	localparam int          HIOAD_MB_AT      = 0;
	localparam int          HIOAD_MB_ECP     = 1;
	localparam int          HIOAD_MB_IDE     = 2;
	localparam logic [7:0]  HIOAD_MODE_RST   = 8'h05;
	localparam logic [7:0]  HIOAD_DOR_RST    = 8'h00;
	localparam int          HIOAD_DOR_MTR    = 4;
	localparam int          HIOAD_BIT7       = 7;

	typedef struct packed {
		logic [9:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
		logic        dma;
	} hioad_req_s;

	typedef struct packed {
		logic [3:0] mtr_oe;
		logic [3:0] ds_oe;
	} hioad_drv_s;
endpackage

// *** hioad_sync.sv ***
// three-flop pin synchroniser that updates once the last two stages agree
`timescale 1ns/1ps
`default_nettype none
module hioad_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_in,
	input  wire logic         srst_in,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

	if (W < 1) begin : g_bad_width
		$error("hioad_sync: width must be positive");
	end

	always_comb begin
		lvl_d = lvl_q;
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) lvl_d[i] = s3_q[i];
		end
	end

	// straps are read during reset, so reset loads the pin level into every stage;
	// skips settling only while reset holds the rest of the block still
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			s1_q  <= pin_in;
			s2_q  <= pin_in;
			s3_q  <= pin_in;
			lvl_q <= pin_in;
		end else begin
			s1_q  <= pin_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign level_out = lvl_q;
endmodule
`default_nettype wire

// *** hioad_drive.sv ***
// motor enable and drive select decode from the digital output register
`timescale 1ns/1ps
`default_nettype none
module hioad_drive
	import hioad_pkg::*;
(
	input  wire logic                  ref_clk_in,
	input  wire logic                  srst_in,
	input  wire logic [7:0]            dor_in,
	input  wire logic                  ecp_in,
	input  wire logic                  enable_in,
	output hioad_pkg::hioad_drv_s      drv_out
);
	hioad_drv_s drv_d, drv_q;
	logic [3:0] mtr;
	logic [1:0] sel;

	always_comb begin
		mtr   = dor_in[HIOAD_DOR_MTR +: 4];
		sel   = dor_in[1:0];
		drv_d = '0;
		if (enable_in) begin
			if (!ecp_in) begin
				drv_d.mtr_oe = mtr;
				drv_d.ds_oe[sel] = mtr[sel];
			end else begin
				drv_d.mtr_oe[1:0] = sel & {2{mtr[sel]}};
				drv_d.ds_oe[1:0]  = sel & {2{mtr[sel]}};
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) drv_q <= '0;
		else drv_q <= drv_d;
	end

	assign drv_out = drv_q;

	property p_ds_qual;
		@(posedge ref_clk_in) disable iff (srst_in)
		(enable_in && !ecp_in) |=> (drv_out.ds_oe == ($past(mtr) & (4'h1 << $past(sel))));
	endproperty
	a_ds_qual: assert property (p_ds_qual) else $error("drive select not decoded");

	property p_ecp_two;
		@(posedge ref_clk_in) disable iff (srst_in)
		$past(ecp_in) |-> (drv_out.ds_oe[3:2] == 2'h0 && drv_out.mtr_oe[3:2] == 2'h0);
	endproperty
	a_ecp_two: assert property (p_ecp_two) else $error("ecp drove lines 2-3");
endmodule
`default_nettype wire

// *** hioad_top.sv ***
// host i/o address decode, configuration glue and drive outputs
// Contract
// - at mode buffers ide bit 7
// - read of 3F7 returns disk change
// - xt mode leaves ide bit 7 idle
// - power invalid: ignore inputs, release outputs
// - registers kept while power invalid
// - game select low at 201 adapter
// - parallel strap latched during reset in adapter mode
// - drive selects decoded, motor qualified
// - four motor outputs from register
// - ecp uses only lines 0 and 1
// - byte registers, ide data word wide
// - block bases relocatable by configuration
// - power-up serial and parallel bases
// - 3F0/3F1 writes config, reads floppy
// - address shared by direction and mode
// - programmed i/o and dma both accepted
// - config changes only in config mode
// - status reads disabled in config mode
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hioad_top
	import hioad_pkg::*;
(
	input  wire logic                  ref_clk_in,
	input  wire logic                  srst_in,
	input  wire hioad_pkg::hioad_req_s req_in,
	input  wire logic                  aen_in,
	output logic [15:0]                rdata_out,
	input  wire logic [15:0]           periph_rdata_in,
	input  wire logic                  disk_change_in,
	input  wire logic                  power_valid_in,
	input  wire logic                  adapter_mode_in,
	input  wire logic                  parallel_mode_strap_in,
	output logic                       parallel_mode_out,
	output logic                       floppy_sel_out,
	output logic                       ide_cs0_n_out,
	output logic                       ide_cs1_n_out,
	output logic                       com1_sel_out,
	output logic                       com2_sel_out,
	output logic                       par_sel_out,
	output logic                       game_port_select_n_out,
	output logic                       game_port_select_oe_out,
	input  wire logic                  ide_data_bit7_in,
	output logic                       ide_data_bit7_out,
	output logic                       ide_data_bit7_oe_out,
	output logic [3:0]                 motor_enable_out,
	output logic [3:0]                 motor_enable_oe_out,
	output logic [3:0]                 drive_select_out,
	output logic [3:0]                 drive_select_oe_out,
	output logic                       config_mode_out
);
	import hioad_pkg::*;

	function automatic logic in_blk8(input logic [9:0] a, input logic [7:0] base);
		in_blk8 = (a[9:3] == base[7:1]);
	endfunction

	logic [2:0] pins;
	logic       pv, adapter, strap;
	hioad_sync #(.W(3)) u_sync (
		.ref_clk_in (ref_clk_in),
		.srst_in    (srst_in),
		.pin_in     ({power_valid_in, adapter_mode_in, parallel_mode_strap_in}),
		.level_out  (pins)
	);
	assign pv      = pins[2];
	assign adapter = pins[1];
	assign strap   = pins[0];

	// configuration state
	logic       cfg_mode_q, cfg_mode_d, armed_q, armed_d;
	logic [7:0] idx_q, idx_d, mode_q, mode_d, dor_q, dor_d;
	logic [7:0] fdc_q, fdc_d, ide_q, ide_d, com1_q, com1_d;
	logic [7:0] com2_q, com2_d, par_q, par_d;
	logic       strap_q, strap_d;
	logic [15:0] rdata_q, rdata_d;
	logic       i7_out_q, i7_out_d, i7_oe_q, i7_oe_d;

	logic       at, ecp, ide_en;
	logic       acc, io, wr, rd;
	logic [9:0] a;
	logic       hit_fdc, hit_ide0, hit_ide1, hit_c1, hit_c2, hit_par;
	logic       hit_cfg0, hit_cfg1, hit_game, ide_any;
	logic [2:0] fo;

	assign at     = mode_q[HIOAD_MB_AT];
	assign ecp    = mode_q[HIOAD_MB_ECP];
	assign ide_en = mode_q[HIOAD_MB_IDE] && at;
	assign a      = req_in.addr;
	assign fo     = a[2:0];

	always_comb begin
		acc = pv && (req_in.wr || req_in.rd);
		io  = acc && !aen_in && !req_in.dma;
		wr  = io && req_in.wr;
		rd  = io && req_in.rd;
		hit_fdc  = io && in_blk8(a, fdc_q);
		hit_ide0 = io && ide_en && in_blk8(a, ide_q);
		hit_ide1 = io && ide_en && (a[9:1] == (({ide_q, 2'h0} + HIOAD_IDE_ALT) >> 1));
		hit_c1   = io && in_blk8(a, com1_q);
		hit_c2   = io && in_blk8(a, com2_q);
		hit_par  = io && (a[9:2] == par_q) && (a[1:0] <= HIOAD_PAR_LAST);
		hit_cfg0 = io && (a == HIOAD_CFG_INDEX);
		hit_cfg1 = io && (a == HIOAD_CFG_DATA);
		hit_game = io && adapter && (a == HIOAD_GAME_ADDR);
		ide_any  = hit_ide0 || hit_ide1;
	end

	always_comb begin
		floppy_sel_out = 1'b0;
		if (hit_fdc) begin
			// programmed i/o writes to 3F0/3F1 never reach the floppy
			if (fo == HIOAD_FO_STA || fo == HIOAD_FO_STB) begin
				floppy_sel_out = rd && !cfg_mode_q;
			end else begin
				floppy_sel_out = 1'b1;
			end
		end
		if (acc && req_in.dma) floppy_sel_out = 1'b1;
	end

	// 3F7 selects both ide and floppy
	assign ide_cs0_n_out           = !hit_ide0;
	assign ide_cs1_n_out           = !hit_ide1;
	assign com1_sel_out            = hit_c1;
	assign com2_sel_out            = hit_c2;
	assign par_sel_out             = hit_par;
	assign game_port_select_n_out  = !hit_game;
	assign game_port_select_oe_out = pv;

	always_comb begin
		cfg_mode_d = cfg_mode_q;
		armed_d    = armed_q;
		idx_d      = idx_q;
		mode_d     = mode_q;
		fdc_d      = fdc_q;
		ide_d      = ide_q;
		com1_d     = com1_q;
		com2_d     = com2_q;
		par_d      = par_q;
		dor_d      = dor_q;
		if (wr && hit_cfg0) begin
			// two enter keys in a row open config mode
			if (!cfg_mode_q) begin
				armed_d    = (req_in.wdata[7:0] == HIOAD_KEY_ENTER);
				cfg_mode_d = armed_q && (req_in.wdata[7:0] == HIOAD_KEY_ENTER);
			end else if (req_in.wdata[7:0] == HIOAD_KEY_EXIT) begin
				cfg_mode_d = 1'b0;
				armed_d    = 1'b0;
			end else begin
				idx_d = req_in.wdata[7:0];
			end
		end else if (wr) begin
			armed_d = 1'b0;
		end
		// data writes count only in config mode
		if (wr && hit_cfg1 && cfg_mode_q) begin
			case (idx_q)
				HIOAD_CR_MODE: mode_d = req_in.wdata[7:0];
				HIOAD_CR_FDC:  fdc_d  = req_in.wdata[7:0];
				HIOAD_CR_IDE:  ide_d  = req_in.wdata[7:0];
				HIOAD_CR_COM1: com1_d = req_in.wdata[7:0];
				HIOAD_CR_COM2: com2_d = req_in.wdata[7:0];
				HIOAD_CR_PAR:  par_d  = req_in.wdata[7:0];
				default:       mode_d = mode_q;
			endcase
		end
		if (wr && hit_fdc && fo == HIOAD_FO_DOR) dor_d = req_in.wdata[7:0];
	end

	function automatic logic [7:0] cfg_read(input logic [7:0] i, input logic [7:0] m,
		input logic [7:0] f, input logic [7:0] d, input logic [7:0] c1,
		input logic [7:0] c2, input logic [7:0] p);
		case (i)
			HIOAD_CR_MODE: cfg_read = m;
			HIOAD_CR_FDC:  cfg_read = f;
			HIOAD_CR_IDE:  cfg_read = d;
			HIOAD_CR_COM1: cfg_read = c1;
			HIOAD_CR_COM2: cfg_read = c2;
			HIOAD_CR_PAR:  cfg_read = p;
			default:       cfg_read = 8'h00;
		endcase
	endfunction

	always_comb begin
		rdata_d  = 16'h0000;
		i7_out_d = 1'b0;
		i7_oe_d  = 1'b0;
		if (rd || (acc && req_in.dma && req_in.rd)) begin
			// byte wide unless ide data port
			rdata_d[7:0] = periph_rdata_in[7:0];
			if (hit_ide0 && fo == 3'h0) rdata_d[15:8] = periph_rdata_in[15:8];
			if (hit_cfg1 && cfg_mode_q) begin
				rdata_d[7:0] = cfg_read(idx_q, mode_q, fdc_q, ide_q, com1_q, com2_q, par_q);
			end else if (hit_fdc && fo == HIOAD_FO_DOR) begin
				rdata_d[7:0] = dor_q;
			end else if (hit_cfg0 || hit_cfg1) begin
				if (cfg_mode_q) rdata_d[7:0] = 8'h00;
			end
			if (ide_any) begin
				// bit 7 taken from the ide line
				rdata_d[HIOAD_BIT7] = ide_data_bit7_in;
			end
			if (hit_ide1 && fo[0]) begin
				// disk change owns bit 7 on this read
				rdata_d[HIOAD_BIT7] = disk_change_in;
			end
		end
		// buffer host bit 7 out on ide writes
		if (wr && ide_any) begin
			i7_oe_d  = 1'b1;
			i7_out_d = req_in.wdata[HIOAD_BIT7];
		end
	end

	always_comb begin
		strap_d = strap_q;
		// follow the strap only while reset holds
		if (srst_in && adapter) strap_d = strap;
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			cfg_mode_q <= 1'b0;
			armed_q    <= 1'b0;
			idx_q      <= 8'h00;
			mode_q     <= HIOAD_MODE_RST;
			fdc_q      <= HIOAD_FDC_RST;
			ide_q      <= HIOAD_IDE_RST;
			com1_q     <= HIOAD_COM1_RST;
			com2_q     <= HIOAD_COM2_RST;
			par_q      <= HIOAD_PAR_RST;
			dor_q      <= HIOAD_DOR_RST;
			rdata_q    <= 16'h0000;
			i7_out_q   <= 1'b0;
			i7_oe_q    <= 1'b0;
		end else begin
			cfg_mode_q <= cfg_mode_d;
			armed_q    <= armed_d;
			idx_q      <= idx_d;
			mode_q     <= mode_d;
			fdc_q      <= fdc_d;
			ide_q      <= ide_d;
			com1_q     <= com1_d;
			com2_q     <= com2_d;
			par_q      <= par_d;
			dor_q      <= dor_d;
			rdata_q    <= rdata_d;
			i7_out_q   <= i7_out_d;
			i7_oe_q    <= i7_oe_d;
		end
	end

	// strap register is loaded by reset itself, so it sits outside the reset branch
	always_ff @(posedge ref_clk_in) begin
		strap_q <= strap_d;
	end

	hioad_drv_s drv;
	hioad_drive u_drive (
		.ref_clk_in (ref_clk_in),
		.srst_in    (srst_in),
		.dor_in     (dor_q),
		.ecp_in     (ecp),
		.enable_in  (pv),
		.drv_out    (drv)
	);

	assign motor_enable_out     = 4'h0;
	assign drive_select_out     = 4'h0;
	assign motor_enable_oe_out  = drv.mtr_oe & {4{pv}};
	assign drive_select_oe_out  = drv.ds_oe & {4{pv}};
	assign ide_data_bit7_out    = i7_out_q;
	// only ide writes in at mode enable it
	assign ide_data_bit7_oe_out = i7_oe_q && pv;
	assign rdata_out            = rdata_q;
	assign parallel_mode_out    = strap_q;
	assign config_mode_out      = cfg_mode_q;

	sequence s_rd_dir;
		rd && hit_ide1 && fo[0];
	endsequence

	property p_game;
		@(posedge ref_clk_in) disable iff (srst_in)
		(pv && adapter && req_in.rd && !aen_in && !req_in.dma && a == HIOAD_GAME_ADDR)
			|-> !game_port_select_n_out;
	endproperty
	a_game: assert property (p_game) else $error("game select missing");

	property p_dchg;
		@(posedge ref_clk_in) disable iff (srst_in)
		s_rd_dir |=> (rdata_out[HIOAD_BIT7] == $past(disk_change_in));
	endproperty
	a_dchg: assert property (p_dchg) else $error("disk change bit wrong");

	property p_xt_idle;
		@(posedge ref_clk_in) disable iff (srst_in)
		!at ##1 !at |-> !ide_data_bit7_oe_out;
	endproperty
	a_xt_idle: assert property (p_xt_idle) else $error("ide bit 7 driven in xt");

	property p_pv_off;
		@(posedge ref_clk_in) disable iff (srst_in)
		!pv |-> (motor_enable_oe_out == 4'h0 && !ide_data_bit7_oe_out && !floppy_sel_out
			&& ide_cs0_n_out && game_port_select_n_out);
	endproperty
	a_pv_off: assert property (p_pv_off) else $error("output active without power");

	property p_keep;
		@(posedge ref_clk_in) disable iff (srst_in)
		!pv |=> ($stable(mode_q) && $stable(fdc_q) && $stable(dor_q) && $stable(cfg_mode_q));
	endproperty
	a_keep: assert property (p_keep) else $error("state changed without power");

	property p_strap;
		@(posedge ref_clk_in) !srst_in |=> $stable(parallel_mode_out);
	endproperty
	a_strap: assert property (p_strap) else $error("strap changed after reset");

	property p_cfg_wr;
		@(posedge ref_clk_in) disable iff (srst_in)
		(req_in.wr && (a == HIOAD_CFG_INDEX || a == HIOAD_CFG_DATA)) |-> !floppy_sel_out
			|| req_in.dma;
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("config write reached floppy");

	property p_locked;
		@(posedge ref_clk_in) disable iff (srst_in)
		!cfg_mode_q |=> ($stable(mode_q) && $stable(ide_q) && $stable(par_q));
	endproperty
	a_locked: assert property (p_locked) else $error("config changed outside mode");

	property p_aen;
		@(posedge ref_clk_in) disable iff (srst_in)
		aen_in |-> (ide_cs0_n_out && !com1_sel_out && !par_sel_out);
	endproperty
	a_aen: assert property (p_aen) else $error("decode during dma cycle");
endmodule
`default_nettype wire

// *** hioad_host.sv ***
// host processor model: programmed i/o and dma strobes on the request bus
`timescale 1ns/1ps
`default_nettype none
module hioad_host
	import hioad_pkg::*;
(
	input  wire logic             ref_clk_in,
	input  wire logic [15:0]      rdata_in,
	input  wire logic [6:0]       sel_in,
	output hioad_pkg::hioad_req_s req_out,
	output logic                  aen_out
);
	import hioad_pkg::*;
	initial begin
		req_out = '0;
		aen_out = 1'b0;
	end
	task automatic set_aen(input logic v);
		@(posedge ref_clk_in);
		aen_out <= v;
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic dma);
		@(posedge ref_clk_in);
		req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, dma: dma};
		@(posedge ref_clk_in);
		// released bus lines do not keep the last value
		req_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0, dma: 1'b0};
	endtask
	task automatic rd(input logic [9:0] a, input logic dma,
		output logic [15:0] d, output logic [6:0] s);
		@(posedge ref_clk_in);
		req_out <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, dma: dma};
		#1 s = sel_in;
		@(posedge ref_clk_in);
		req_out <= '{addr: ~a, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b0, dma: 1'b0};
		#1 d = rdata_in;
	endtask
	// key sequence then index and value
	task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
		wr(HIOAD_CFG_INDEX, {8'h00, HIOAD_KEY_ENTER}, 1'b0);
		wr(HIOAD_CFG_INDEX, {8'h00, HIOAD_KEY_ENTER}, 1'b0);
		wr(HIOAD_CFG_INDEX, {8'h00, idx}, 1'b0);
		wr(HIOAD_CFG_DATA, {8'h00, val}, 1'b0);
		wr(HIOAD_CFG_INDEX, {8'h00, HIOAD_KEY_EXIT}, 1'b0);
	endtask
endmodule
`default_nettype wire

// *** hioad_top_bench.sv ***
// self-checking bench for the host i/o decode block
`timescale 1ns/1ps
`default_nettype none
module hioad_top_bench;
	import hioad_pkg::*;
	logic             ref_clk_in;
	logic             srst_in;
	hioad_req_s       req;
	logic             aen;
	logic [15:0]      rdata, periph, d;
	logic             disk_chg, pwr, adapter, strap, drv_bit7, pin7;
	logic             par_mode, fsel, cs0_n, cs1_n, c1sel, c2sel, psel, game_n, game_oe;
	logic             b7_out, b7_oe, cfg_mode;
	logic [3:0]       mtr, mtr_oe, ds, ds_oe;
	logic [6:0]       s;
	int               error_cnt, comparisons, cyc;
	logic [9:0]       map_a [9] = '{10'h3F8, 10'h3FF, 10'h2F8, 10'h2FF, 10'h278, 10'h27A,
		10'h27B, 10'h201, 10'h1F0};
	logic [6:0]       map_s [9] = '{7'h27, 7'h27, 7'h17, 7'h17, 7'h0F, 7'h0F, 7'h07, 7'h03,
		7'h05};
	logic [7:0]       dor_v [4] = '{8'h02, 8'h21, 8'hF3, 8'h11};
	logic [7:0]       dor_e [4] = '{8'h00, 8'h22, 8'hF8, 8'h10};

	// ide bit 7 wire: device drives when enabled, else the drive
	assign pin7 = b7_oe ? b7_out : drv_bit7;

	hioad_host u_host (
		.ref_clk_in (ref_clk_in),
		.rdata_in   (rdata),
		.sel_in     ({fsel, c1sel, c2sel, psel, game_n, cs0_n, cs1_n}),
		.req_out    (req),
		.aen_out    (aen)
	);

	hioad_top u_dut (
		.ref_clk_in              (ref_clk_in),
		.srst_in                 (srst_in),
		.req_in                  (req),
		.aen_in                  (aen),
		.rdata_out               (rdata),
		.periph_rdata_in         (periph),
		.disk_change_in          (disk_chg),
		.power_valid_in          (pwr),
		.adapter_mode_in         (adapter),
		.parallel_mode_strap_in  (strap),
		.parallel_mode_out       (par_mode),
		.floppy_sel_out          (fsel),
		.ide_cs0_n_out           (cs0_n),
		.ide_cs1_n_out           (cs1_n),
		.com1_sel_out            (c1sel),
		.com2_sel_out            (c2sel),
		.par_sel_out             (psel),
		.game_port_select_n_out  (game_n),
		.game_port_select_oe_out (game_oe),
		.ide_data_bit7_in        (pin7),
		.ide_data_bit7_out       (b7_out),
		.ide_data_bit7_oe_out    (b7_oe),
		.motor_enable_out        (mtr),
		.motor_enable_oe_out     (mtr_oe),
		.drive_select_out        (ds),
		.drive_select_oe_out     (ds_oe),
		.config_mode_out         (cfg_mode)
	);

	always #2 ref_clk_in = ~ref_clk_in;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic dor_chk(input logic [7:0] v, input logic [7:0] e);
		u_host.wr(10'h3F2, {8'h00, v}, 1'b0);
		@(posedge ref_clk_in);
		#1 check({8'h00, mtr_oe, ds_oe}, {8'h00, e});
	endtask

	// hang guard, far above the expected run length
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		ref_clk_in = 1'b0;
		srst_in = 1'b1;
		periph = 16'h12B4;
		disk_chg = 1'b1;
		pwr = 1'b1;
		adapter = 1'b1;
		strap = 1'b1;
		drv_bit7 = 1'b1;
		error_cnt = 0;
		comparisons = 0;
		cyc = 0;
		repeat (2) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		repeat (6) @(posedge ref_clk_in);
		check({15'h0000, par_mode}, 16'h0001);
		for (int i = 0; i < 9; i++) begin
			u_host.rd(map_a[i], 1'b0, d, s);
			check({9'h000, s}, {9'h000, map_s[i]});
		end
		u_host.rd(10'h3F8, 1'b0, d, s);
		check(d, 16'h00B4);
		u_host.rd(10'h1F0, 1'b0, d, s);
		check(d, 16'h12B4);
		u_host.rd(10'h3F0, 1'b0, d, s);
		check({9'h000, s}, 16'h0047);
		// disk change wins over the drive on bit 7
		periph <= 16'h1234;
		drv_bit7 <= 1'b0;
		u_host.rd(10'h3F7, 1'b0, d, s);
		check({15'h0000, d[7]}, 16'h0001);
		check({9'h000, s}, 16'h0046);
		for (int i = 0; i < 3; i++) begin
			u_host.wr(i == 0 ? 10'h1F0 : (i == 1 ? 10'h3F6 : 10'h3F7),
				{8'h00, i[0], 7'h00}, 1'b0);
			#1 check({14'h0000, b7_oe, b7_out}, {14'h0000, 1'b1, i[0]});
			@(posedge ref_clk_in);
			#1 check({15'h0000, b7_oe}, 16'h0000);
		end
		for (int i = 0; i < 4; i++) dor_chk(dor_v[i], dor_e[i]);
		check({8'h00, mtr, ds}, 16'h0000);
		pwr <= 1'b0;
		repeat (6) @(posedge ref_clk_in);
		#1 check({7'h00, game_oe, mtr_oe, ds_oe}, 16'h0000);
		u_host.wr(10'h3F2, 16'h00F3, 1'b0);
		pwr <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		#1 check({7'h00, game_oe, mtr_oe, ds_oe}, 16'h0110);
		u_host.set_aen(1'b1);
		u_host.rd(10'h3F8, 1'b0, d, s);
		check({9'h000, s}, 16'h0007);
		u_host.rd(10'h3F8, 1'b1, d, s);
		check({9'h000, s}, 16'h0047);
		u_host.set_aen(1'b0);
		// index and value outside configuration mode must not land
		u_host.wr(HIOAD_CFG_INDEX, {8'h00, HIOAD_CR_COM1}, 1'b0);
		u_host.wr(HIOAD_CFG_DATA, 16'h00BA, 1'b0);
		u_host.rd(10'h3F8, 1'b0, d, s);
		check({9'h000, s}, 16'h0027);
		u_host.wr(HIOAD_CFG_INDEX, {8'h00, HIOAD_KEY_ENTER}, 1'b0);
		u_host.wr(HIOAD_CFG_INDEX, {8'h00, HIOAD_KEY_ENTER}, 1'b0);
		@(posedge ref_clk_in);
		#1 check({15'h0000, cfg_mode}, 16'h0001);
		u_host.rd(10'h3F0, 1'b0, d, s);
		check({s, d[8:0]}, 16'h0E00);
		u_host.wr(HIOAD_CFG_INDEX, {8'h00, HIOAD_CR_COM1}, 1'b0);
		u_host.wr(HIOAD_CFG_DATA, 16'h00BA, 1'b0);
		u_host.rd(HIOAD_CFG_DATA, 1'b0, d, s);
		check(d, 16'h00BA);
		u_host.wr(HIOAD_CFG_INDEX, {8'h00, HIOAD_KEY_EXIT}, 1'b0);
		u_host.rd(10'h2E8, 1'b0, d, s);
		check({9'h000, s}, 16'h0027);
		u_host.rd(10'h3F8, 1'b0, d, s);
		check({9'h000, s}, 16'h0007);
		u_host.cfg(HIOAD_CR_MODE, 8'h07);
		dor_chk(8'h21, 8'h11);
		dor_chk(8'hF3, 8'h33);
		u_host.cfg(HIOAD_CR_MODE, 8'h04);
		u_host.wr(10'h1F0, 16'h0080, 1'b0);
		#1 check({15'h0000, b7_oe}, 16'h0000);
		strap <= 1'b0;
		srst_in <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		strap <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		check({14'h0000, par_mode, cfg_mode}, 16'h0000);
		u_host.rd(10'h3F8, 1'b0, d, s);
		check({9'h000, s}, 16'h0027);
		stop_test();
	end
endmodule
`default_nettype wire
